// File: verilog/afst_pkg.sv
// Purpose: shared constants for the sample timing and power-on reset block
// Assumes: one 125 MHz system clock standing in for the master clock
// Notes:   control register offsets and defaults live here
package afst_pkg;
  localparam int          DataW          = 16;
  localparam int          AddrW          = 4;
  localparam int          LatencyCycles  = 7;
  localparam int          SyncStages     = 2;
  localparam int          PipeDepth      = 23;  // deepest tap 22: 4+15+3
  localparam logic [3:0]  RegCtrl        = 4'h0;
  localparam logic [3:0]  RegDelay       = 4'h1;
  localparam logic [3:0]  RegSoftReset   = 4'h2;
  localparam logic [3:0]  RegStatus      = 4'h3;
  localparam logic [3:0]  RegAdcData     = 4'h4;
  localparam logic [3:0]  RegId          = 4'h5;
  // ctrl field positions
  localparam int          CtrlDualBit    = 0;
  localparam int          CtrlAutoBit    = 1;
  localparam int          CtrlSdoAdcBit  = 2;
  localparam int          CtrlDivLo      = 4;
  localparam int          CtrlOeDelLo    = 6;
  localparam logic [7:0]  CtrlReset      = 8'h00;
  localparam logic [3:0]  DelayReset     = 4'h0;
  localparam logic [15:0] IdValue        = 16'h5A31; // arbitrary value
  localparam logic [15:0] SoftResetKey   = 16'h00A5;
endpackage : afst_pkg

// File: verilog/afst_ser_if.sv
// Purpose: serial output path between the core and its shifter
// Assumes: all signals on clk_sys
// Notes:   shifter loads a word on load and shifts on falling serial clock
`timescale 1ns/1ps
`default_nettype none
interface afst_ser_if;
  logic        load;
  logic [15:0] word;
  logic        sckFall;
  logic        bitOut;
  modport core (output load, output word, output sckFall, input bitOut);
  modport shift (input load, input word, input sckFall, output bitOut);
endinterface : afst_ser_if
`default_nettype wire

// File: verilog/afst_ser_shift.sv
// Purpose: serial data output shifter
// Assumes: falling serial clock already detected on clk_sys
// Notes:   msb first; output changes only on load or after a falling serial edge
`timescale 1ns/1ps
`default_nettype none
module afst_ser_shift (
  input  wire logic clk_sys,
  input  wire logic resetn,
  afst_ser_if.shift ser
);
  logic [15:0] shift_q;
  logic [15:0] shift_d;

  always_comb begin
    shift_d = shift_q;
    if (ser.load) begin
      shift_d = ser.word;
    end else if (ser.sckFall) begin
      shift_d = {shift_q[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      shift_q <= 16'h0000;
    end else begin
      shift_q <= shift_d;
    end
  end

  assign ser.bitOut = shift_q[15];

  shift_moves_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!ser.load && !ser.sckFall) |=> $stable(shift_q))
    else $error("shifter moved without a serial edge");
endmodule : afst_ser_shift
`default_nettype wire

// File: verilog/afst_core.sv
// Purpose: sample strobes, output latency, output enable and power-on gate
// Assumes: master clock equals clk_sys; pins synchronised here
// Notes:   simple parallel port stands in for the serial write path
//
// Notes on behaviour
// - single-sample strobe routes video and clamp level
// - data appears 7 clocks after strobe fall with zero delay and divider code 00
// - supply monitor low holds power-on reset
// - writes ignored while power-on reset active
// - registers default on release, writes then accepted
// - bus enable by pin or automatic delay
// - serial out gives registers or converter data
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module afst_core (
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  input  wire logic                  analogSupplyOk,
  input  wire logic                  digitalSupplyOk,
  input  wire logic                  videoSampleStrobe,
  input  wire logic                  resetSampleStrobe,
  input  wire logic                  outputEnableN,
  input  wire logic                  serialClk,
  input  wire logic [15:0]           adcData,
  input  wire logic [3:0]            regAddr,
  input  wire logic [15:0]           regWdata,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic      [15:0]           regRdata,
  output logic                       videoCapConnect,
  output logic                       resetCapVideo,
  output logic                       resetCapClamp,
  output logic                       clampSwitch,
  output logic      [15:0]           opData,
  output logic                       opDataOe,
  output logic                       serialDataOut,
  output logic                       powerOnResetN
);
  // pin synchronisers: first stage read only by the second
  logic [1:0] vsS1_q, rsS1_q, oeS1_q, scS1_q;
  logic [1:0] anS1_q;
  logic       vs, rs, oeN, sck, supplyOk;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      vsS1_q <= 2'h0;
      rsS1_q <= 2'h0;
      oeS1_q <= 2'h3;
      scS1_q <= 2'h0;
      anS1_q <= 2'h0;
    end else begin
      vsS1_q <= {vsS1_q[0], videoSampleStrobe};
      rsS1_q <= {rsS1_q[0], resetSampleStrobe};
      oeS1_q <= {oeS1_q[0], outputEnableN};
      scS1_q <= {scS1_q[0], serialClk};
      anS1_q <= {anS1_q[0], analogSupplyOk & digitalSupplyOk};
    end
  end
  assign vs       = vsS1_q[1];
  assign rs       = rsS1_q[1];
  assign oeN      = oeS1_q[1];
  assign sck      = scS1_q[1];
  assign supplyOk = anS1_q[1];

  // delayed copies for edge detection, fed from second stage only
  logic vsPrev_q, sckPrev_q;
  logic vsFall, sckFall;
  assign vsFall  = vsPrev_q & ~vs;
  assign sckFall = sckPrev_q & ~sck;

  // power-on reset gate
  logic porActive;
  assign porActive     = ~supplyOk;
  assign powerOnResetN = supplyOk;

  // control registers
  logic [7:0]  ctrl_q, ctrl_d;
  logic [3:0]  delay_q, delay_d;
  logic        wrOk;
  logic        softReset;
  assign wrOk      = regWr & ~porActive;
  assign softReset = wrOk && regAddr == afst_pkg::RegSoftReset
                     && regWdata == afst_pkg::SoftResetKey;

  always_comb begin
    ctrl_d  = ctrl_q;
    delay_d = delay_q;
    if (porActive || softReset) begin
      ctrl_d  = afst_pkg::CtrlReset;
      delay_d = afst_pkg::DelayReset;
    end else if (wrOk && regAddr == afst_pkg::RegCtrl) begin
      ctrl_d = regWdata[7:0];
    end else if (wrOk && regAddr == afst_pkg::RegDelay) begin
      delay_d = regWdata[3:0];
    end
  end

  logic dualMode, autoTri, sdoAdc;
  logic [1:0] clkDiv, oeDelay;
  assign dualMode = ctrl_q[afst_pkg::CtrlDualBit];
  assign autoTri  = ctrl_q[afst_pkg::CtrlAutoBit];
  assign sdoAdc   = ctrl_q[afst_pkg::CtrlSdoAdcBit];
  assign clkDiv   = ctrl_q[afst_pkg::CtrlDivLo +: 2];
  assign oeDelay  = ctrl_q[afst_pkg::CtrlOeDelLo +: 2];

  // sampling switch routing
  always_comb begin
    videoCapConnect = vs;
    resetCapVideo   = dualMode & rs;
    resetCapClamp   = ~dualMode & vs;
    clampSwitch     = rs;
  end

  // latency pipe: data captured at vs fall, tap picks total delay
  logic [15:0] pipe_q [afst_pkg::PipeDepth];
  logic        vpipe_q [afst_pkg::PipeDepth];
  logic [4:0]  tap;
  // divider setting extends latency by its code; 00 gives the base figure;
  // latency counts from the pin, so the synchroniser stages are taken off
  assign tap = 5'(afst_pkg::LatencyCycles - afst_pkg::SyncStages - 1)
               + {1'b0, delay_q} + {3'b000, clkDiv};
  logic [15:0] opData_d;
  logic        opOe_d, opOe_q, opValid;
  assign opValid = vpipe_q[tap];
  always_comb begin
    opData_d = opValid ? pipe_q[tap] : opData;
    // auto mode: enable leads valid data by oeDelay clocks
    if (autoTri) begin
      opOe_d = (oeDelay == 2'b00) ? opValid
             : vpipe_q[5'(tap - {3'b000, oeDelay})];
    end else begin
      opOe_d = ~oeN;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_q    <= afst_pkg::CtrlReset;
      delay_q   <= afst_pkg::DelayReset;
      vsPrev_q  <= 1'b0;
      sckPrev_q <= 1'b0;
      opData    <= 16'h0000;
      opOe_q    <= 1'b0;
      for (int i = 0; i < afst_pkg::PipeDepth; i++) begin
        pipe_q[i]  <= 16'h0000;
        vpipe_q[i] <= 1'b0;
      end
    end else begin
      ctrl_q     <= ctrl_d;
      delay_q    <= delay_d;
      vsPrev_q   <= vs;
      sckPrev_q  <= sck;
      opData     <= opData_d;
      opOe_q     <= opOe_d;
      pipe_q[0]  <= adcData;
      vpipe_q[0] <= vsFall;
      for (int i = 1; i < afst_pkg::PipeDepth; i++) begin
        pipe_q[i]  <= pipe_q[i-1];
        vpipe_q[i] <= vpipe_q[i-1];
      end
    end
  end
  assign opDataOe = opOe_q;

  // register read port, data one cycle after the strobe
  logic [15:0] rd_d;
  always_comb begin
    case (regAddr)
      afst_pkg::RegCtrl:   rd_d = {8'h00, ctrl_q};
      afst_pkg::RegDelay:  rd_d = {12'h000, delay_q};
      afst_pkg::RegStatus: rd_d = {14'h0000, opOe_q, porActive};
      afst_pkg::RegAdcData: rd_d = opData;
      afst_pkg::RegId:     rd_d = afst_pkg::IdValue;
      default:             rd_d = 16'h0000;
    endcase
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 16'h0000;
    end else begin
      regRdata <= regRd ? rd_d : 16'h0000;
    end
  end

  // serial output: load on read strobe, register or converter word
  afst_ser_if ser ();
  assign ser.load    = regRd;
  assign ser.word    = sdoAdc ? opData : rd_d;
  assign ser.sckFall = sckFall;
  afst_ser_shift u_shift (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ser     (ser)
  );
  assign serialDataOut = ser.bitOut;

  // checks
  single_sample_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!dualMode && vs) |-> (videoCapConnect && resetCapClamp))
    else $error("single-sample routing wrong");
  latency_seven_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (vsFall && delay_q == 4'h0 && clkDiv == 2'b00 && !porActive)
      ##1 (delay_q == 4'h0 && clkDiv == 2'b00)[*5]
      |=> opData == $past(adcData, 6))
    else $error("output latency not seven");
  por_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!analogSupplyOk || !digitalSupplyOk) |-> ##2 !powerOnResetN)
    else $error("reset released under low supply");
  write_drop_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    porActive |=> (ctrl_q == afst_pkg::CtrlReset))
    else $error("write taken during power-on reset");
  default_regs_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(supplyOk) |-> delay_q == afst_pkg::DelayReset)
    else $error("registers not default at release");
  pin_enable_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!autoTri && $stable(oeN)) |=> opDataOe == ~$past(oeN))
    else $error("output enable does not follow pin");
  auto_enable_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (autoTri && oeDelay == 2'b00) |=> opDataOe == $past(opValid))
    else $error("automatic enable wrong");
  serial_src_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (regRd && sdoAdc) |=> serialDataOut == $past(opData[15]))
    else $error("serial output source wrong");
endmodule : afst_core
`default_nettype wire

// File: verif/afst_ctrl_model.sv
// Purpose: imaging controller model driving sample strobes and serial clock
// Assumes: every pin changes just after a rising clk_sys edge
// Notes:   serial clock rests low outside frames
`timescale 1ns/1ps
`default_nettype none
module afst_ctrl_model (
  input  wire logic clk_sys,
  output logic      vsStrobe,
  output logic      rsStrobe,
  output logic      serClk
);
  initial begin
    vsStrobe = 1'b0;
    rsStrobe = 1'b0;
    serClk   = 1'b0;
  end
  // strobe high for hi clocks; period never under the three-clock floor
  task automatic pixel(input int hi, input int period, input logic clamp);
    @(posedge clk_sys);
    vsStrobe <= 1'b1;
    rsStrobe <= clamp;
    repeat (hi) @(posedge clk_sys);
    vsStrobe <= 1'b0;
    rsStrobe <= 1'b0;
    repeat ((period < 3 ? 3 : period) - hi) @(posedge clk_sys);
  endtask : pixel
  // slow edges so the two-flop synchroniser sees every level
  task automatic ser_pulse();
    repeat (3) @(posedge clk_sys);
    serClk <= 1'b1;
    repeat (3) @(posedge clk_sys);
    serClk <= 1'b0;
  endtask : ser_pulse
endmodule : afst_ctrl_model
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: self-checking bench for the sample timing and reset gate
// Assumes: unmapped register reads return zero
// Notes:   latency counted in clocks from the first edge after strobe fall
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys, resetn, aOk, dOk, oeN, wr, rd;
  logic        vcap, rcapV, rcapC, clampSw, oe, serial_data_out, porN, vs, rs, sck;
  logic [15:0] adc, wdata, rdata, opData, got;
  logic [3:0]  addr;
  int          n_mismatch, n_checks, cyc, k;
  afst_ctrl_model afst_ctrl_model_inst (.clk_sys(clk_sys), .vsStrobe(vs),
    .rsStrobe(rs), .serClk(sck));
  afst_core afst_core_inst (.clk_sys(clk_sys), .resetn(resetn),
    .analogSupplyOk(aOk), .digitalSupplyOk(dOk), .videoSampleStrobe(vs),
    .resetSampleStrobe(rs), .outputEnableN(oeN), .serialClk(sck),
    .adcData(adc), .regAddr(addr), .regWdata(wdata), .regWr(wr),
    .regRd(rd), .regRdata(rdata), .videoCapConnect(vcap),
    .resetCapVideo(rcapV), .resetCapClamp(rcapC), .clampSwitch(clampSw),
    .opData(opData), .opDataOe(oe), .serialDataOut(serial_data_out),
    .powerOnResetN(porN));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    rd <= 1'b1; addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 check("rdata", e, rdata);
  endtask : rd_reg
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_cyc
  // drains older strobe flags first; n counts from the first edge after fall
  task automatic run_pixel(input logic [15:0] d, input logic wantOe,
                           output int n);
    repeat (afst_pkg::PipeDepth) @(posedge clk_sys);
    adc <= d;
    afst_ctrl_model_inst.pixel(1, 3, 1'b0);
    n = 1;
    while ((wantOe ? oe !== 1'b1 : opData !== d) && n < 40) begin
      wait_cyc(1);
      n++;
    end
  endtask : run_pixel
  task automatic shift_out(output logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      w[i] = serial_data_out;
      afst_ctrl_model_inst.ser_pulse();
      wait_cyc(4);
    end
  endtask : shift_out
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ceiling well above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    resetn = 1'b0; aOk = 1'b0; dOk = 1'b0; oeN = 1'b1; wr = 1'b0;
    rd = 1'b0; adc = 16'h0000; wdata = 16'h0000; addr = 4'h0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    wait_cyc(4);
    check("por", 16'h0000, {15'h0, porN});
    rd_reg(afst_pkg::RegStatus, 16'h0001);
    wr_reg(afst_pkg::RegCtrl, 16'h00FF);
    rd_reg(afst_pkg::RegCtrl, {8'h00, afst_pkg::CtrlReset});
    aOk <= 1'b1;
    wait_cyc(4);
    check("por", 16'h0000, {15'h0, porN});
    dOk <= 1'b1;
    wait_cyc(4);
    check("por", 16'h0001, {15'h0, porN});
    wr_reg(afst_pkg::RegSoftReset, afst_pkg::SoftResetKey);
    rd_reg(afst_pkg::RegCtrl, {8'h00, afst_pkg::CtrlReset});
    rd_reg(4'hF, 16'h0000);
    wr_reg(afst_pkg::RegDelay, 16'h0003);
    rd_reg(afst_pkg::RegDelay, 16'h0003);
    aOk <= 1'b0; // brown-out on one supply only
    wait_cyc(4);
    check("por", 16'h0000, {15'h0, porN});
    aOk <= 1'b1;
    wait_cyc(4);
    rd_reg(afst_pkg::RegDelay, {12'h000, afst_pkg::DelayReset});
    fork
      afst_ctrl_model_inst.pixel(4, 6, 1'b1);
      begin
        wait_cyc(4);
        check("caps", 16'h000B,
              {12'h0, vcap, rcapV, rcapC, clampSw});
      end
    join
    run_pixel(16'h1234, 1'b0, k);
    check("latency", 16'(afst_pkg::LatencyCycles), 16'(k));
    oeN <= 1'b0;
    wait_cyc(4);
    check("oe pin", 16'h0001, {15'h0, oe});
    oeN <= 1'b1;
    wait_cyc(4);
    check("oe pin", 16'h0000, {15'h0, oe});
    wr_reg(afst_pkg::RegCtrl, 16'h0001);
    fork
      afst_ctrl_model_inst.pixel(4, 6, 1'b1);
      begin
        wait_cyc(4);
        check("dual caps", 16'h000D,
              {12'h0, vcap, rcapV, rcapC, clampSw});
      end
    join
    wr_reg(afst_pkg::RegCtrl, 16'h0002);
    run_pixel(16'h4321, 1'b1, k);
    check("oe auto", 16'(afst_pkg::LatencyCycles), 16'(k));
    check("oe data", 16'h4321, opData);
    wait_cyc(1);
    check("oe auto off", 16'h0000, {15'h0, oe});
    wr_reg(afst_pkg::RegCtrl, 16'h0052);
    wr_reg(afst_pkg::RegDelay, 16'h0002);
    run_pixel(16'h0F0F, 1'b1, k);
    check("oe lead", 16'(afst_pkg::LatencyCycles + 2), 16'(k));
    wait_cyc(1);
    check("late data", 16'h0F0F, opData);
    rd_reg(afst_pkg::RegAdcData, 16'h0F0F);
    wr_reg(afst_pkg::RegCtrl, 16'h0000);
    rd_reg(afst_pkg::RegId, afst_pkg::IdValue);
    shift_out(got);
    check("serial", afst_pkg::IdValue, got);
    wr_reg(afst_pkg::RegCtrl, 16'h0004);
    rd_reg(afst_pkg::RegId, afst_pkg::IdValue);
    shift_out(got);
    check("serial adc", 16'h0F0F, got);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
